// [core/tpg_pkg.sv]
// Package with register map, field positions and pattern codes of the test pattern generator.
package tpg_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [11:0] TPG_CTRL_ADDR = 12'h0550;
  localparam logic [11:0] TPG_USER_BASE_ADDR = 12'h0551;
  localparam logic [11:0] TPG_USER_LAST_ADDR = 12'h0558;
  localparam logic [7:0] TPG_CTRL_RESET = 8'h00;
  localparam logic [7:0] TPG_USER_RESET = 8'h00;
  localparam logic [7:0] TPG_CTRL_WR_MASK = 8'hBF;

  // ==========================================================================
  // Control field positions.
  localparam int TPG_PLAYBACK_BIT = 7;
  localparam int TPG_LONG_HOLD_BIT = 5;
  localparam int TPG_SHORT_HOLD_BIT = 4;
  localparam int TPG_SEL_MSB = 3;

  // ==========================================================================
  // Pattern select codes.
  typedef enum logic [3:0] {
    TPG_SEL_OFF = 4'b0000,
    TPG_SEL_MID = 4'b0001,
    TPG_SEL_POS = 4'b0010,
    TPG_SEL_NEG = 4'b0011,
    TPG_SEL_CHECK = 4'b0100,
    TPG_SEL_PN_LONG = 4'b0101,
    TPG_SEL_PN_SHORT = 4'b0110,
    TPG_SEL_TOGGLE = 4'b0111,
    TPG_SEL_USER = 4'b1000
  } tpg_sel_e;

  // ==========================================================================
  // Fixed words and generator seeds.
  localparam logic [15:0] TPG_WORD_MID = 16'h8000;
  localparam logic [15:0] TPG_WORD_POS = 16'hFFFF;
  localparam logic [15:0] TPG_WORD_NEG = 16'h0000;
  localparam logic [15:0] TPG_WORD_CHECK_A = 16'hAAAA;
  localparam logic [15:0] TPG_WORD_CHECK_B = 16'h5555;
  localparam logic [15:0] TPG_WORD_ONES = 16'hFFFF;
  localparam logic [15:0] TPG_WORD_ZERO = 16'h0000;
  localparam logic [22:0] TPG_LONG_SEED = 23'h7F_FFFF;
  localparam logic [8:0] TPG_SHORT_SEED = 9'h1FF;
  localparam logic [22:0] TPG_LONG_TAPS = 23'h42_0000;
  localparam logic [8:0] TPG_SHORT_TAPS = 9'h110;

endpackage

// [core/tpg_lfsr.sv]
// Galois pseudorandom generator with a synchronous hold-in-reset input.
`timescale 1ns/1ps
module tpg_lfsr
  import tpg_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter logic [WIDTH-1:0] SEED = '1,
  parameter logic [WIDTH-1:0] TAPS = '1
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Control.
  input wire logic hold_in,
  // State.
  output logic [WIDTH-1:0] state_out
);

  logic [WIDTH-1:0] state_r;
  logic [WIDTH-1:0] state_nxt;

  always_comb begin
    if (hold_in) begin
      state_nxt = SEED;
    end else if (state_r[0]) begin
      state_nxt = (state_r >> 1) ^ TAPS;
    end else begin
      state_nxt = state_r >> 1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_r <= SEED;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign state_out = state_r;

endmodule

// [core/tpg_gen.sv]
// Output test pattern generator with its control and user word registers.
//
// Overview of operation
// - A 4-bit select field passes converter data at 0000 and above 1000, and otherwise substitutes midscale, full scale, checkerboard, PN, toggle or user words.
// - Select 1000 emits the four user words, sequenced by the playback bit.
// - The playback bit 7 matters only while the select field is 1000.
// - With playback 0 the user words 1 to 4 play one cycle each, repeating forever.
// - With playback 1 the user words 1 to 4 play once, then zeros follow forever.
// - Control bit 5 at 1 holds the long PN generator in reset, at 0 it runs.
// - Control bit 4 at 1 holds the short PN generator in reset, at 0 it runs.
// - Each user word is a low and a high byte register, word one at 0x551/0x552, later words at the next pairs.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module tpg_gen
  import tpg_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 12,
  parameter int LONG_W = 23,
  parameter int SHORT_W = 9
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Sample stream.
  input wire logic [DATA_W-1:0] adc_data_in,
  output logic [DATA_W-1:0] sample_out,
  output logic pattern_active_out
);

  // ==========================================================================
  // Registers.
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] user_r [0:7];
  logic [7:0] user_nxt [0:7];
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  function automatic logic user_hit(input logic [ADDR_W-1:0] a);
    return (a >= TPG_USER_BASE_ADDR) && (a <= TPG_USER_LAST_ADDR);
  endfunction

  function automatic logic [2:0] user_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - TPG_USER_BASE_ADDR;
    return d[2:0];
  endfunction

  // Strobe decode of the register port.
  logic ctrl_wr_hit;
  logic user_wr_hit;
  logic ctrl_rd_hit;
  logic user_rd_hit;

  assign ctrl_wr_hit = reg_wr_in && (reg_addr_in == TPG_CTRL_ADDR);
  assign user_wr_hit = reg_wr_in && user_hit(reg_addr_in);
  assign ctrl_rd_hit = reg_rd_in && (reg_addr_in == TPG_CTRL_ADDR);
  assign user_rd_hit = reg_rd_in && user_hit(reg_addr_in);

  // Reserved bit 6 is masked on write, so it always reads back as zero.
  // Read data stand for one cycle only and are zero otherwise, which also
  // covers every unmapped address.
  always_comb begin
    ctrl_nxt = ctrl_r;
    for (int i = 0; i < 8; i++) begin
      user_nxt[i] = user_r[i];
    end
    rdata_nxt = 8'h00;
    if (ctrl_wr_hit) begin
      ctrl_nxt = reg_wdata_in & TPG_CTRL_WR_MASK;
    end
    if (user_wr_hit) begin
      user_nxt[user_idx(reg_addr_in)] = reg_wdata_in;
    end
    if (ctrl_rd_hit) begin
      rdata_nxt = ctrl_r;
    end else if (user_rd_hit) begin
      rdata_nxt = user_r[user_idx(reg_addr_in)];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl_r <= TPG_CTRL_RESET;
      for (int i = 0; i < 8; i++) begin
        user_r[i] <= TPG_USER_RESET;
      end
      rdata_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      for (int i = 0; i < 8; i++) begin
        user_r[i] <= user_nxt[i];
      end
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

  // ==========================================================================
  // Pseudorandom generators.
  // Both generators run whatever the selection; only their hold bits and rst_in
  // reseed them, so a switch to a PN pattern picks the sequence up where it stands.
  logic [LONG_W-1:0] long_state;
  logic [SHORT_W-1:0] short_state;

  tpg_lfsr #(
    .WIDTH(LONG_W),
    .SEED(TPG_LONG_SEED),
    .TAPS(TPG_LONG_TAPS)
  ) u_long (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .hold_in(ctrl_r[TPG_LONG_HOLD_BIT]),
    .state_out(long_state)
  );

  tpg_lfsr #(
    .WIDTH(SHORT_W),
    .SEED(TPG_SHORT_SEED),
    .TAPS(TPG_SHORT_TAPS)
  ) u_short (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .hold_in(ctrl_r[TPG_SHORT_HOLD_BIT]),
    .state_out(short_state)
  );

  // ==========================================================================
  // Pattern sequencing and output.
  logic [2:0] step_r;
  logic [2:0] step_nxt;
  logic phase_r;
  logic phase_nxt;
  logic [DATA_W-1:0] sample_r;
  logic [DATA_W-1:0] sample_nxt;
  logic active_r;
  logic active_nxt;
  logic [3:0] sel;
  logic [DATA_W-1:0] user_word;
  logic single_done;

  localparam logic [2:0] STEP_DONE = 3'h4;

  assign sel = ctrl_r[TPG_SEL_MSB:0];

  // ==========================================================================
  // Word sequencing.
  // The step counter restarts at word one whenever user mode is left and
  // keeps its place when only the playback bit changes. Step four is the
  // resting state of single playback; repeat playback reads it as word one.
  always_comb begin
    step_nxt = 3'h0;
    phase_nxt = ~phase_r;
    if (sel == TPG_SEL_USER) begin
      if (!ctrl_r[TPG_PLAYBACK_BIT]) begin
        step_nxt = {1'b0, step_r[1:0] + 2'h1};
      end else if (step_r != STEP_DONE) begin
        step_nxt = step_r + 3'h1;
      end else begin
        step_nxt = STEP_DONE;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      step_r <= 3'h0;
      phase_r <= 1'b0;
    end else begin
      step_r <= step_nxt;
      phase_r <= phase_nxt;
    end
  end

  // ==========================================================================
  // Output word selection.
  // The odd-indexed byte of each user pair is the high half of the word.
  assign user_word = {user_r[{step_r[1:0], 1'b1}],
    user_r[{step_r[1:0], 1'b0}]};
  assign single_done = ctrl_r[TPG_PLAYBACK_BIT] && (step_r == STEP_DONE);

  always_comb begin
    active_nxt = (sel != TPG_SEL_OFF);
    unique case (sel)
      TPG_SEL_OFF: sample_nxt = adc_data_in;
      TPG_SEL_MID: sample_nxt = TPG_WORD_MID;
      TPG_SEL_POS: sample_nxt = TPG_WORD_POS;
      TPG_SEL_NEG: sample_nxt = TPG_WORD_NEG;
      TPG_SEL_CHECK: begin
        sample_nxt = phase_r ? TPG_WORD_CHECK_B : TPG_WORD_CHECK_A;
      end
      TPG_SEL_PN_LONG: sample_nxt = long_state[DATA_W-1:0];
      TPG_SEL_PN_SHORT: begin
        // Nine bits fill the word by repeating the low seven of them.
        sample_nxt = {short_state[6:0], short_state};
      end
      TPG_SEL_TOGGLE: begin
        sample_nxt = phase_r ? TPG_WORD_ZERO : TPG_WORD_ONES;
      end
      TPG_SEL_USER: begin
        sample_nxt = single_done ? TPG_WORD_ZERO : user_word;
      end
      // Spare codes above user mode pass converter data.
      default: sample_nxt = adc_data_in;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sample_r <= '0;
      active_r <= 1'b0;
    end else begin
      sample_r <= sample_nxt;
      active_r <= active_nxt;
    end
  end

  assign sample_out = sample_r;
  assign pattern_active_out = active_r;

endmodule

// [tb/tpg_gen_props.sv]
// Port checks of the test pattern generator.
`timescale 1ns/1ps
module tpg_gen_props
  import tpg_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Register port.
  input wire logic [11:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Sample stream.
  input wire logic [15:0] adc_data_in,
  input wire logic [15:0] sample_out,
  input wire logic pattern_active_out
);
  // ==========================================================================
  // Shadow of the control register.
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [3:0] sel;
  assign sel = ctrl_r[3:0];
  always_comb ctrl_nxt = (reg_wr_in && reg_addr_in == TPG_CTRL_ADDR) ?
    reg_wdata_in & TPG_CTRL_WR_MASK : ctrl_r;
  always_ff @(posedge clk_sys_in) ctrl_r <= rst_in ? TPG_CTRL_RESET : ctrl_nxt;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence s_single; (sel == 4'h8 && ctrl_r[7]) [*5]; endsequence
  sequence s_repeat; (sel == 4'h8 && !ctrl_r[7] && !reg_wr_in) [*5];
  endsequence
  property p_ctrl_rd; reg_rd_in && reg_addr_in == TPG_CTRL_ADDR
    |=> reg_rdata_out == $past(ctrl_r); endproperty
  property p_unmapped; reg_rd_in && !(reg_addr_in inside
    {[TPG_CTRL_ADDR:TPG_USER_LAST_ADDR]}) |=> reg_rdata_out == 8'h00;
  endproperty
  property p_pass; sel == 4'h0 |=> sample_out == $past(adc_data_in);
  endproperty
  property p_active; 1'b1 |=> pattern_active_out == ($past(sel) != 4'h0);
  endproperty
  property p_mid; sel == 4'h1 |=> sample_out == TPG_WORD_MID; endproperty
  property p_inv; (sel == 4'h4 || sel == 4'h7) && $stable(sel)
    |=> sample_out == ~$past(sample_out); endproperty
  property p_single; s_single |=> sample_out == 16'h0000; endproperty
  property p_repeat; s_repeat |=> sample_out == $past(sample_out, 4);
  endproperty
  property p_hold; ((sel == 4'h5 && ctrl_r[5]) || (sel == 4'h6 && ctrl_r[4]))
    [*3] |=> $stable(sample_out); endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  a_pass: assert property (p_pass) else $error("pass data");
  a_active: assert property (p_active) else $error("active flag");
  a_mid: assert property (p_mid) else $error("midscale");
  a_inv: assert property (p_inv) else $error("alternation");
  a_single: assert property (p_single) else $error("single play");
  a_repeat: assert property (p_repeat) else $error("repeat play");
  a_hold: assert property (p_hold) else $error("prbs hold");
endmodule
bind tpg_gen tpg_gen_props i_props (.clk_sys_in, .rst_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .adc_data_in,
  .sample_out, .pattern_active_out);

// [tb/tpg_sink.sv]
// Downstream formatter model that latches every generated word.
`timescale 1ns/1ps
module tpg_sink (
  // Clock.
  input wire logic clk_sys_in,
  // Stream.
  input wire logic [15:0] word_in,
  output logic [15:0] word_out
);
  always_ff @(posedge clk_sys_in) word_out <= word_in;
endmodule

// [tb/tb.sv]
// Self-checking testbench of the test pattern generator.
`timescale 1ns/1ps
module tb
  import tpg_pkg::*;
;
  logic clk_sys_in, rst_in, reg_wr_in, reg_rd_in, pattern_active_out;
  logic [11:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out;
  logic [15:0] adc_data_in, sample_out, word, w0;
  logic [15:0] uw [4];
  logic [15:0] fx [4] = '{16'h0000, TPG_WORD_MID, TPG_WORD_POS, TPG_WORD_NEG};
  int mismatches = 0;
  int tests_run = 0;
  tpg_gen i_dut (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .adc_data_in, .sample_out,
    .pattern_active_out);
  tpg_sink i_sink (.clk_sys_in, .word_in(sample_out), .word_out(word));
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in)
    adc_data_in <= rst_in ? 16'h0000 : adc_data_in + 16'h0001;
  // ==========================================================================
  // Bus and check tasks.
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 chk({8'h00, reg_rdata_out}, {8'h00, e});
  endtask
  task automatic see(input logic [15:0] e);
    @(posedge clk_sys_in);
    #1 chk(word, e);
  endtask
  task automatic pair(input logic [7:0] v, input int gap);
    wr(TPG_CTRL_ADDR, v);
    repeat (3) @(posedge clk_sys_in);
    #1 w0 = word;
    repeat (gap) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================================================
  // Test sequence.
  initial begin
    {rst_in, reg_wr_in, reg_rd_in} = 3'b100;
    reg_addr_in = 12'h000;
    reg_wdata_in = 8'h00;
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (int a = 12'h54F; a < 12'h55A; a++) rd(a[11:0], 8'h00);
    chk({15'h0000, pattern_active_out}, 16'h0000);
    wr(12'h559, 8'hFF);
    rd(12'h559, 8'h00);
    wr(TPG_CTRL_ADDR, 8'hFF);
    rd(TPG_CTRL_ADDR, 8'hBF);
    chk({15'h0000, pattern_active_out}, 16'h0001);
    pair(8'h00, 0);
    chk(word, adc_data_in - 16'h0002);
    for (int c = 1; c < 8; c++) begin
      pair({4'hB, c[3:0]}, 1);
      chk((c == 4 || c == 7) ? ~w0 : w0, word);
      if (c < 4) chk(w0, fx[c]);
    end
    pair(8'h15, 40);
    chk({15'h0000, word !== w0}, 16'h0001);
    pair(8'h26, 40);
    chk({15'h0000, word !== w0}, 16'h0001);
    for (int a = 12'h551; a < 12'h559; a++) wr(a[11:0], a[7:0]);
    for (int a = 12'h551; a < 12'h559; a++) rd(a[11:0], a[7:0]);
    foreach (uw[n]) uw[n] = {8'h52 + 8'(2 * n), 8'h51 + 8'(2 * n)};
    wr(TPG_CTRL_ADDR, 8'h08);
    @(posedge clk_sys_in);
    for (int i = 0; i < 10; i++) see(uw[i % 4]);
    chk({15'h0000, pattern_active_out}, 16'h0001);
    wr(TPG_CTRL_ADDR, 8'h00);
    wr(TPG_CTRL_ADDR, 8'h88);
    @(posedge clk_sys_in);
    for (int i = 0; i < 8; i++) see(i < 4 ? uw[i] : 16'h0000);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1 chk(sample_out, 16'h0000);
    chk({15'h0000, pattern_active_out}, 16'h0000);
    rd(TPG_CTRL_ADDR, 8'h00);
    final_report();
  end
  initial begin
    repeat (4000) @(posedge clk_sys_in);
    mismatches++;
    final_report();
  end
endmodule
